// File: pkg/supervisor_pkg.sv
// constants, register map and state types for the supply supervisor with watchdog
package supervisor_pkg;
  // timebase
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_HZ = 1_000_000;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  // times as specified, and their counts in microsecond ticks
  localparam int T_RST_MS = 200;
  localparam int T_WD_OPEN_MS = 1600;
  localparam int T_WD_PULLUP_MS = 200;
  localparam int T_INIT_US = 390;
  localparam int T_SETUP_US = 140;
  localparam int RST_TICKS = T_RST_MS * 1000;
  localparam int WD_OPEN_TICKS = T_WD_OPEN_MS * 1000;
  localparam int WD_PULLUP_TICKS = T_WD_PULLUP_MS * 1000;
  localparam int INIT_PHASE_TICKS = T_INIT_US / 2;
  localparam int SETUP_TICKS = T_SETUP_US;
  // register byte offsets
  localparam logic [7:0] REG_CAP_TIMEOUT = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [31:0] CAP_TIMEOUT_RESET = 32'h0000_03E8;
  // status register fields
  localparam int ST_RST_OUT = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_CLASS_LSB = 2;
  localparam int ST_CFG_DONE = 4;
  localparam int ST_WD_LIVE = 5;
  localparam int ST_SETUP = 6;
  localparam int ST_ENABLE = 7;
  // interrupt bits
  localparam int IRQ_W = 4;
  localparam int IRQ_WD_TIMEOUT = 0;
  localparam int IRQ_RST_ASSERT = 1;
  localparam int IRQ_RST_RELEASE = 2;
  localparam int IRQ_CFG_DONE = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;
  // configuration pin classes
  localparam logic [1:0] CLS_OPEN = 2'h0;
  localparam logic [1:0] CLS_PULLUP = 2'h1;
  localparam logic [1:0] CLS_CAP = 2'h2;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {R_HOLD, R_DELAY, R_RUN} rst_state_t;
  typedef enum logic [1:0] {C_IDLE, C_SINK, C_SOURCE, C_DONE} cfg_state_t;
endpackage

// File: design/interval_timer.sv
// restartable down-counting interval timer stepped by a tick enable
`timescale 1ns/100ps
module interval_timer #(
  parameter int W = 32
) (
  input logic clock,
  input logic srst,
  input logic start,
  input logic stop,
  input logic tick,
  input logic [W-1:0] limit,
  output logic running,
  output logic [W-1:0] count,
  output logic expire
);
  // start wins over stop so a restart in the same cycle is never lost
  always_ff @(posedge clock) begin
    if (srst) begin
      running <= 1'b0;
      count <= '0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (start) begin
        running <= 1'b1;
        count <= limit;
      end else if (stop) begin
        running <= 1'b0;
      end else if (running && tick) begin
        if (count <= W'(1)) begin
          running <= 1'b0;
          count <= '0;
          expire <= 1'b1;
        end else begin
          count <= count - W'(1);
        end
      end
    end
  end
endmodule

// File: design/supply_supervisor_watchdog.sv
// supply supervisor with reset delay, watchdog fault output and AXI4-Lite registers
//
// Overview of operation
// RL1 - reset output goes low whenever comparator reports supply below lower threshold
// RL2 - after supply recovers, reset stays low for the reset delay, then releases
// RL3 - reset delay is 200 ms; fault pulse uses the same period
// RL4 - each entry to valid supply classifies config pin as open, pull-up or capacitor
// RL5 - open pin gives 1600 ms timeout, pull-up gives 200 ms, when enabled
// RL6 - capacitor option takes its timeout from a software register
// RL7 - only kick falling edges count; each restarts the timeout; the code ignores kicks while a fault pulse is active
// RL8 - host must kick before the minimum timeout elapses
// RL9 - kick interval beyond the timeout pulls fault low, else fault stays high
// RL10 - an asserted fault stays low for the reset delay, then releases
// RL11 - a watchdog timeout never asserts the system reset
// RL12 - while reset is asserted, watchdog is off, kicks ignored, fault released
// RL13 - on reset release the watchdog resumes and listens to kicks again
// RL14 - reset asserting during a fault releases the fault at once
// RL15 - enable pin low keeps watchdog off, kicks ignored, fault never asserted
// RL16 - enable pin high runs the watchdog normally under reset gating
// RL17 - after enable rises, kicks are ignored for a 140 us set-up interval
// RL18 - below minimum operating supply, reset low, kicks ignored, fault released
// RL19 - comparator result, hysteresis included, arrives as a synchronised digital input
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module supply_supervisor_watchdog #(
  parameter int TW = 32,
  parameter int TICK_CYCLES = supervisor_pkg::TICK_CYCLES,
  parameter int RST_TICKS = supervisor_pkg::RST_TICKS,
  parameter int WD_OPEN_TICKS = supervisor_pkg::WD_OPEN_TICKS,
  parameter int WD_PULLUP_TICKS = supervisor_pkg::WD_PULLUP_TICKS,
  parameter int INIT_PHASE_TICKS = supervisor_pkg::INIT_PHASE_TICKS,
  parameter int SETUP_TICKS = supervisor_pkg::SETUP_TICKS
) (
  input logic CLOCK,
  input logic SRST,
  input logic UV_ABOVE,
  input logic VMIN_OK,
  input logic KICK_IN,
  input logic WD_ENABLE,
  input logic TIMEOUT_CFG_PIN,
  output logic TIMEOUT_CFG_SINK,
  output logic TIMEOUT_CFG_SOURCE,
  output logic SYS_RST_OUT_N,
  output logic SYS_RST_OE,
  output logic WD_FAULT_OUT_N,
  output logic WD_FAULT_OE,
  output logic IRQ,
  input logic [7:0] AWADDR,
  input logic AWVALID,
  output logic AWREADY,
  input logic [31:0] WDATA,
  input logic [3:0] WSTRB,
  input logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input logic BREADY,
  input logic [7:0] ARADDR,
  input logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input logic RREADY
);
  logic [2:0] uv_sync, vmin_sync, en_sync, cfg_sync;
  logic [3:0] kick_sync;
  logic supply_good, en_s, en_prev, kick_fall, wd_live, supply_prev;
  logic [15:0] tick_cnt;
  logic us_tick;
  supervisor_pkg::rst_state_t rst_state;
  supervisor_pkg::cfg_state_t cfg_state;
  logic [1:0] cfg_class;
  logic [TW-1:0] cap_timeout, wd_limit, wd_count;
  logic rst_start, rst_expire, rst_running;
  logic init_start, init_expire, init_running;
  logic setup_running, setup_expire;
  logic wd_start, wd_stop, wd_running, wd_expire;
  logic flt_expire, flt_running;
  logic fault;
  localparam int IRQ_W_L = supervisor_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] irq_status, irq_mask, irq_set, irq_clr;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_got, w_got;

  // two stages before any logic looks at the pins; kick keeps a third for the edge
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      uv_sync <= 3'h0;
      vmin_sync <= 3'h0;
      en_sync <= 3'h0;
      cfg_sync <= 3'h0;
      kick_sync <= 4'h0;
    end else begin
      uv_sync <= {uv_sync[1:0], UV_ABOVE}; // [RL19]
      vmin_sync <= {vmin_sync[1:0], VMIN_OK};
      en_sync <= {en_sync[1:0], WD_ENABLE};
      cfg_sync <= {cfg_sync[1:0], TIMEOUT_CFG_PIN};
      kick_sync <= {kick_sync[2:0], KICK_IN};
    end
  end
  assign supply_good = uv_sync[1] && vmin_sync[1]; // [RL18]
  assign en_s = en_sync[1];
  assign en_prev = en_sync[2];
  assign kick_fall = kick_sync[2] && !kick_sync[1]; // [RL7]

  // microsecond tick; timers step on it, so each interval is short by under one tick
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      tick_cnt <= 16'h0000;
      us_tick <= 1'b0;
    end else if (tick_cnt == 16'(TICK_CYCLES - 1)) begin
      tick_cnt <= 16'h0000;
      us_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      us_tick <= 1'b0;
    end
  end

  // system reset: low on undervoltage, released after the delay; the watchdog never touches it [RL11]
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rst_state <= supervisor_pkg::R_HOLD;
      SYS_RST_OUT_N <= 1'b0;
      SYS_RST_OE <= 1'b1;
      supply_prev <= 1'b0;
    end else begin
      supply_prev <= supply_good;
      if (!supply_good) begin
        rst_state <= supervisor_pkg::R_HOLD; // [RL1]
        SYS_RST_OUT_N <= 1'b0;
        SYS_RST_OE <= 1'b1;
      end else begin
        case (rst_state)
          supervisor_pkg::R_HOLD: rst_state <= supervisor_pkg::R_DELAY; // [RL2]
          supervisor_pkg::R_DELAY: begin
            if (rst_expire) begin
              rst_state <= supervisor_pkg::R_RUN; // [RL2]
              SYS_RST_OUT_N <= 1'b1;
              SYS_RST_OE <= 1'b0;
            end
          end
          supervisor_pkg::R_RUN: rst_state <= supervisor_pkg::R_RUN;
          default: rst_state <= supervisor_pkg::R_HOLD;
        endcase
      end
    end
  end
  assign rst_start = supply_good && (rst_state == supervisor_pkg::R_HOLD);

  interval_timer #(.W(TW)) rst_tmr (
    .clock(CLOCK), .srst(SRST), .start(rst_start), .stop(!supply_good), .tick(us_tick),
    .limit(TW'(RST_TICKS)), .running(rst_running), .count(), .expire(rst_expire) // [RL3]
  );

  // config pin probe: weak sink first (pull-up resistor wins), then weak source
  // (open pin rises at once, a capacitor is still charging when the phase ends)
  // the source phase is armed only for a low pin, so a pull-up leaves no stray phase running
  assign init_start = (supply_good && !supply_prev)
                      || (cfg_state == supervisor_pkg::C_SINK && init_expire && !cfg_sync[1]);
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      cfg_state <= supervisor_pkg::C_IDLE;
      cfg_class <= supervisor_pkg::CLS_OPEN;
      TIMEOUT_CFG_SINK <= 1'b0;
      TIMEOUT_CFG_SOURCE <= 1'b0;
    end else if (!supply_good) begin
      cfg_state <= supervisor_pkg::C_IDLE;
      TIMEOUT_CFG_SINK <= 1'b0;
      TIMEOUT_CFG_SOURCE <= 1'b0;
    end else begin
      case (cfg_state)
        supervisor_pkg::C_IDLE: begin
          if (!supply_prev) begin
            cfg_state <= supervisor_pkg::C_SINK; // [RL4]
            TIMEOUT_CFG_SINK <= 1'b1;
          end
        end
        supervisor_pkg::C_SINK: begin
          if (init_expire) begin
            TIMEOUT_CFG_SINK <= 1'b0;
            if (cfg_sync[1]) begin
              cfg_class <= supervisor_pkg::CLS_PULLUP; // [RL4]
              cfg_state <= supervisor_pkg::C_DONE;
            end else begin
              cfg_state <= supervisor_pkg::C_SOURCE;
              TIMEOUT_CFG_SOURCE <= 1'b1;
            end
          end
        end
        supervisor_pkg::C_SOURCE: begin
          if (init_expire) begin
            TIMEOUT_CFG_SOURCE <= 1'b0;
            cfg_class <= cfg_sync[1] ? supervisor_pkg::CLS_OPEN : supervisor_pkg::CLS_CAP; // [RL4]
            cfg_state <= supervisor_pkg::C_DONE;
          end
        end
        supervisor_pkg::C_DONE: cfg_state <= supervisor_pkg::C_DONE;
        default: cfg_state <= supervisor_pkg::C_IDLE;
      endcase
    end
  end

  interval_timer #(.W(TW)) init_tmr (
    .clock(CLOCK), .srst(SRST), .start(init_start), .stop(!supply_good), .tick(us_tick),
    .limit(TW'(INIT_PHASE_TICKS)), .running(init_running), .count(), .expire(init_expire)
  );

  // kicks are deaf for the set-up interval after the enable pin rises
  interval_timer #(.W(TW)) setup_tmr (
    .clock(CLOCK), .srst(SRST), .start(en_s && !en_prev), .stop(!en_s), .tick(us_tick),
    .limit(TW'(SETUP_TICKS)), .running(setup_running), .count(), .expire(setup_expire) // [RL17]
  );

  // watchdog runs only out of reset, enabled, and with the pin classified
  assign wd_live = supply_good && rst_state == supervisor_pkg::R_RUN && en_s
                   && cfg_state == supervisor_pkg::C_DONE; // [RL12] [RL13] [RL15] [RL16]
  always_comb begin
    case (cfg_class)
      supervisor_pkg::CLS_OPEN: wd_limit = TW'(WD_OPEN_TICKS); // [RL5]
      supervisor_pkg::CLS_PULLUP: wd_limit = TW'(WD_PULLUP_TICKS); // [RL5]
      default: wd_limit = cap_timeout; // [RL6]
    endcase
  end
  // restart on a kick, on going live, and when a fault pulse ends
  assign wd_start = wd_live && !fault && ((kick_fall && !setup_running) || !wd_running) && !wd_expire; // [RL7]
  assign wd_stop = !wd_live;

  interval_timer #(.W(TW)) wd_tmr (
    .clock(CLOCK), .srst(SRST), .start(wd_start), .stop(wd_stop), .tick(us_tick),
    .limit(wd_limit), .running(wd_running), .count(wd_count), .expire(wd_expire)
  );

  // fault pulse; leaving the live state drops it at once
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      fault <= 1'b0;
      WD_FAULT_OUT_N <= 1'b1;
      WD_FAULT_OE <= 1'b0;
    end else if (!wd_live) begin
      fault <= 1'b0; // [RL12] [RL14] [RL15] [RL18]
      WD_FAULT_OUT_N <= 1'b1;
      WD_FAULT_OE <= 1'b0;
    end else if (wd_expire) begin
      fault <= 1'b1; // [RL9]
      WD_FAULT_OUT_N <= 1'b0;
      WD_FAULT_OE <= 1'b1;
    end else if (flt_expire) begin
      fault <= 1'b0; // [RL10]
      WD_FAULT_OUT_N <= 1'b1;
      WD_FAULT_OE <= 1'b0;
    end
  end

  interval_timer #(.W(TW)) flt_tmr (
    .clock(CLOCK), .srst(SRST), .start(wd_live && wd_expire), .stop(!wd_live), .tick(us_tick),
    .limit(TW'(RST_TICKS)), .running(flt_running), .count(), .expire(flt_expire) // [RL10]
  );

  // interrupts: sticky, cleared by reading, a new event in the read cycle survives
  always_comb begin
    irq_set = '0;
    irq_set[supervisor_pkg::IRQ_WD_TIMEOUT] = wd_live && wd_expire;
    irq_set[supervisor_pkg::IRQ_RST_ASSERT] = !supply_good && rst_state != supervisor_pkg::R_HOLD;
    irq_set[supervisor_pkg::IRQ_RST_RELEASE] = supply_good && rst_state == supervisor_pkg::R_DELAY && rst_expire;
    irq_set[supervisor_pkg::IRQ_CFG_DONE] = init_expire && cfg_state != supervisor_pkg::C_IDLE
                                            && (cfg_state == supervisor_pkg::C_SOURCE || cfg_sync[1]);
    irq_clr = (ARVALID && ARREADY && ARADDR == supervisor_pkg::REG_IRQ_STATUS) ? irq_status : '0;
  end
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      irq_status <= '0;
      IRQ <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
      IRQ <= |(irq_status & irq_mask);
    end
  end

  // write channel: address and data taken in either order, answer after both
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= supervisor_pkg::RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      cap_timeout <= TW'(supervisor_pkg::CAP_TIMEOUT_RESET);
      irq_mask <= supervisor_pkg::IRQ_MASK_RESET;
    end else begin
      if (AWREADY && AWVALID) begin
        AWREADY <= 1'b0;
        aw_got <= 1'b1;
        aw_addr <= AWADDR;
      end else if (!aw_got && !BVALID) begin
        AWREADY <= 1'b1;
      end
      if (WREADY && WVALID) begin
        WREADY <= 1'b0;
        w_got <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end else if (!w_got && !BVALID) begin
        WREADY <= 1'b1;
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end else if (aw_got && w_got && !BVALID) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= supervisor_pkg::RESP_OKAY;
        case (aw_addr)
          supervisor_pkg::REG_CAP_TIMEOUT: begin
            for (int b = 0; b < 4; b++) begin
              if (w_strb[b]) cap_timeout[8*b +: 8] <= w_data[8*b +: 8]; // [RL6]
            end
          end
          supervisor_pkg::REG_IRQ_MASK: begin
            if (w_strb[0]) irq_mask <= w_data[IRQ_W_L-1:0];
          end
          supervisor_pkg::REG_STATUS, supervisor_pkg::REG_IRQ_STATUS: BRESP <= supervisor_pkg::RESP_OKAY;
          default: BRESP <= supervisor_pkg::RESP_DECERR;
        endcase
      end
    end
  end

  // read channel
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= supervisor_pkg::RESP_OKAY;
    end else if (ARREADY && ARVALID) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RRESP <= supervisor_pkg::RESP_OKAY;
      RDATA <= 32'h0000_0000;
      case (ARADDR)
        supervisor_pkg::REG_CAP_TIMEOUT: RDATA <= 32'(cap_timeout);
        supervisor_pkg::REG_STATUS: begin
          RDATA[supervisor_pkg::ST_RST_OUT] <= SYS_RST_OUT_N;
          RDATA[supervisor_pkg::ST_FAULT] <= fault;
          RDATA[supervisor_pkg::ST_CLASS_LSB +: 2] <= cfg_class;
          RDATA[supervisor_pkg::ST_CFG_DONE] <= cfg_state == supervisor_pkg::C_DONE;
          RDATA[supervisor_pkg::ST_WD_LIVE] <= wd_live;
          RDATA[supervisor_pkg::ST_SETUP] <= setup_running;
          RDATA[supervisor_pkg::ST_ENABLE] <= en_s;
        end
        supervisor_pkg::REG_IRQ_STATUS: RDATA[IRQ_W_L-1:0] <= irq_status;
        supervisor_pkg::REG_IRQ_MASK: RDATA[IRQ_W_L-1:0] <= irq_mask;
        default: RRESP <= supervisor_pkg::RESP_DECERR;
      endcase
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end else if (!RVALID) begin
      ARREADY <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);
  logic [31:0] delay_cycles;
  always_ff @(posedge CLOCK) begin
    if (SRST || rst_state != supervisor_pkg::R_DELAY) delay_cycles <= 32'h0000_0000;
    else delay_cycles <= delay_cycles + 32'h0000_0001;
  end

  uv_drives_reset_a: assert property (!supply_good |=> !SYS_RST_OUT_N && SYS_RST_OE) // [RL1]
    else $error("reset not asserted on undervoltage");
  release_after_delay_a: assert property ($rose(SYS_RST_OUT_N) |-> $past(rst_expire) && supply_good) // [RL2]
    else $error("reset released without delay expiry");
  delay_length_a: assert property ($rose(SYS_RST_OUT_N) |-> delay_cycles >= 32'((RST_TICKS - 1) * TICK_CYCLES)) // [RL3]
    else $error("reset delay too short");
  cfg_class_time_a: assert property ((cfg_state == supervisor_pkg::C_SINK) ##1 (cfg_state == supervisor_pkg::C_DONE)
    |-> $past(init_expire) && cfg_class == supervisor_pkg::CLS_PULLUP) // [RL4]
    else $error("config pin classified early");
  kick_restarts_a: assert property (wd_start |=> wd_running && wd_count == $past(wd_limit)) // [RL7]
    else $error("kick did not restart watchdog");
  fault_cause_a: assert property ($fell(WD_FAULT_OUT_N) |-> $past(wd_expire) && $past(wd_live)) // [RL9]
    else $error("fault without timeout");
  fault_hold_a: assert property ($fell(WD_FAULT_OUT_N) ##1 wd_live [*8] |-> !WD_FAULT_OUT_N) // [RL10]
    else $error("fault released early");
  no_reset_on_wd_a: assert property (wd_expire && supply_good |=> SYS_RST_OUT_N) // [RL11]
    else $error("watchdog timeout drove system reset");
  reset_frees_fault_a: assert property (!SYS_RST_OUT_N |-> WD_FAULT_OUT_N && !WD_FAULT_OE) // [RL12] [RL14]
    else $error("fault driven during reset");
  disabled_quiet_a: assert property (!en_s |=> WD_FAULT_OUT_N && !WD_FAULT_OE && !wd_running) // [RL15]
    else $error("fault or timer active while disabled");
  setup_deaf_a: assert property ($rose(en_s) |=> setup_running [*8]) // [RL17]
    else $error("set-up interval missing");
endmodule

// File: testbench/watchdog_host.sv
// host model: periodic watchdog kicks and the timeout config pin network
`timescale 1ns/100ps
module watchdog_host #(
  parameter int HALF = 10
) (
  input wire logic clock,
  input wire logic run,
  input wire logic [1:0] cfg_kind,
  input wire logic sink,
  input wire logic source,
  output logic kick,
  output logic cfg_pin
);
  int cnt = 0;
  logic flip = 1'b0;
  initial kick = 1'b1;
  // a falling edge every 2*HALF cycles, well inside the shortest timeout
  always @(posedge clock) begin
    cnt <= (!run || cnt == HALF - 1) ? 0 : cnt + 1;
    flip <= ~flip;
    if (!run)
      kick <= 1'b1;
    else if (cnt == HALF - 1)
      kick <= ~kick;
  end
  // pull-up beats the weak sink; an open pin floats unless probed; a capacitor stays low
  always_comb begin
    if (cfg_kind == supervisor_pkg::CLS_PULLUP)
      cfg_pin = 1'b1;
    else if (cfg_kind == supervisor_pkg::CLS_OPEN)
      cfg_pin = source ? 1'b1 : (sink ? 1'b0 : flip);
    else
      cfg_pin = 1'b0;
  end
endmodule

// File: testbench/testbench.sv
// self-checking bench for the supply supervisor with watchdog
`timescale 1ns/100ps
module testbench;
  localparam int RT = 20;
  logic CLOCK = 1'b0;
  logic SRST = 1'b1;
  logic UV_ABOVE = 1'b0;
  logic VMIN_OK = 1'b1;
  logic WD_ENABLE = 1'b1;
  logic run = 1'b1;
  logic [1:0] cfg_kind = supervisor_pkg::CLS_PULLUP;
  logic KICK_IN, TIMEOUT_CFG_PIN, TIMEOUT_CFG_SINK, TIMEOUT_CFG_SOURCE;
  logic SYS_RST_OUT_N, SYS_RST_OE, WD_FAULT_OUT_N, WD_FAULT_OE, IRQ;
  logic [7:0] AWADDR = 8'h00;
  logic [7:0] ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0000_0000;
  logic [3:0] WSTRB = 4'hF;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0] BRESP, RRESP, resp;
  logic [31:0] RDATA, rd;
  int errors = 0;
  int checked = 0;
  int n;
  always #2.5 CLOCK = ~CLOCK;
  // short counts keep the run brief; every expectation below is derived from them
  supply_supervisor_watchdog #(.TICK_CYCLES(2), .RST_TICKS(RT), .WD_OPEN_TICKS(60), .WD_PULLUP_TICKS(30),
    .INIT_PHASE_TICKS(5), .SETUP_TICKS(6)) u_supply_supervisor_watchdog (.CLOCK, .SRST, .UV_ABOVE,
    .VMIN_OK, .KICK_IN, .WD_ENABLE, .TIMEOUT_CFG_PIN, .TIMEOUT_CFG_SINK, .TIMEOUT_CFG_SOURCE,
    .SYS_RST_OUT_N, .SYS_RST_OE, .WD_FAULT_OUT_N, .WD_FAULT_OE, .IRQ, .AWADDR, .AWVALID, .AWREADY,
    .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY,
    .RDATA, .RRESP, .RVALID, .RREADY);
  watchdog_host #(.HALF(10)) u_watchdog_host (.clock(CLOCK), .run(run), .cfg_kind(cfg_kind),
    .sink(TIMEOUT_CFG_SINK), .source(TIMEOUT_CFG_SOURCE), .kick(KICK_IN), .cfg_pin(TIMEOUT_CFG_PIN));
  task automatic report_and_stop();
    $display("checks %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic ran_out();
    errors++;
    $display("wrong value at %0t: wait ran out", $time);
    report_and_stop();
  endtask
  // sel 0 watches the reset output, sel 1 the fault output; sampled at falling edges
  task automatic wait_for(input bit sel, input logic v, input int lim, input bit must);
    n = 0;
    do begin
      @(negedge CLOCK);
      n++;
    end while ((sel ? WD_FAULT_OUT_N : SYS_RST_OUT_N) !== v && n < lim);
    if (must && (sel ? WD_FAULT_OUT_N : SYS_RST_OUT_N) !== v)
      ran_out();
  endtask
  // handshakes are judged at the falling edge, since inputs move only at rising edges
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    logic ha, hw;
    logic hb = 1'b0;
    @(posedge CLOCK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!hb && k < 40) begin
      @(negedge CLOCK);
      ha = AWREADY;
      hw = WREADY;
      hb = BVALID;
      resp = BRESP;
      @(posedge CLOCK);
      if (ha) AWVALID <= 1'b0;
      if (hw) WVALID <= 1'b0;
      k++;
    end
    BREADY <= 1'b0;
    if (!hb)
      ran_out();
  endtask
  task automatic bus_read(input logic [7:0] a);
    int k = 0;
    logic ha;
    logic hr = 1'b0;
    @(posedge CLOCK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (!hr && k < 40) begin
      @(negedge CLOCK);
      ha = ARREADY;
      hr = RVALID;
      rd = RDATA;
      resp = RRESP;
      @(posedge CLOCK);
      if (ha) ARVALID <= 1'b0;
      k++;
    end
    RREADY <= 1'b0;
    if (!hr)
      ran_out();
  endtask
  initial begin
    repeat (2) @(posedge CLOCK);
    SRST <= 1'b0;
    @(posedge CLOCK);
    UV_ABOVE <= 1'b1;
    wait_for(0, 1'b1, 200, 1);
    check(n >= 2 * RT && n <= 2 * RT + 8 && SYS_RST_OE === 1'b0, "reset delay");
    bus_read(supervisor_pkg::REG_STATUS);
    check(rd[3:2] === supervisor_pkg::CLS_PULLUP && rd[4] === 1'b1, "pull-up class");
    bus_read(supervisor_pkg::REG_CAP_TIMEOUT);
    check(rd === supervisor_pkg::CAP_TIMEOUT_RESET, "cap timeout reset");
    bus_write(supervisor_pkg::REG_IRQ_MASK, 32'h0000_0001);
    bus_read(supervisor_pkg::REG_IRQ_STATUS);
    wait_for(1, 1'b0, 300, 0);
    check(WD_FAULT_OUT_N === 1'b1, "fault while kicked");
    @(posedge CLOCK);
    run <= 1'b0;
    wait_for(1, 1'b0, 200, 1);
    wait_for(1, 1'b1, 100, 1);
    check(n >= 2 * RT && n <= 2 * RT + 4, "fault pulse length");
    check(SYS_RST_OUT_N === 1'b1 && IRQ === 1'b1, "reset kept or irq");
    wait_for(1, 1'b0, 100, 1);
    check(n >= 60 && n <= 66, "pull-up timeout");
    bus_write(supervisor_pkg::REG_IRQ_MASK, 32'h0000_0000);
    @(negedge CLOCK);
    check(IRQ === 1'b0 && WD_FAULT_OUT_N === 1'b0, "masked irq, fault held");
    bus_read(supervisor_pkg::REG_IRQ_STATUS);
    check(rd[0] === 1'b1, "timeout event");
    @(posedge CLOCK);
    UV_ABOVE <= 1'b0;
    run <= 1'b1;
    wait_for(0, 1'b0, 4, 1);
    @(negedge CLOCK);
    check(WD_FAULT_OUT_N === 1'b1 && WD_FAULT_OE === 1'b0 && SYS_RST_OE === 1'b1, "fault released");
    wait_for(1, 1'b0, 200, 0);
    check(WD_FAULT_OUT_N === 1'b1, "kicks during reset");
    bus_write(supervisor_pkg::REG_CAP_TIMEOUT, 32'h0000_0028);
    // open pin first, then the capacitor class with its register timeout
    for (int i = 0; i < 2; i++) begin
      @(posedge CLOCK);
      UV_ABOVE <= 1'b0;
      run <= 1'b0;
      repeat (6) @(posedge CLOCK);
      cfg_kind <= i ? supervisor_pkg::CLS_CAP : supervisor_pkg::CLS_OPEN;
      UV_ABOVE <= 1'b1;
      wait_for(0, 1'b1, 100, 1);
      wait_for(1, 1'b0, 300, 1);
      wait_for(1, 1'b1, 100, 1);
      wait_for(1, 1'b0, 200, 1);
      check(n >= (i ? 80 : 120) && n <= (i ? 86 : 126), "fixed or cap timeout");
      bus_read(supervisor_pkg::REG_STATUS);
      check(rd[3:2] === (i ? supervisor_pkg::CLS_CAP : supervisor_pkg::CLS_OPEN), "class");
    end
    @(posedge CLOCK);
    WD_ENABLE <= 1'b0;
    repeat (4) @(posedge CLOCK);
    wait_for(1, 1'b0, 300, 0);
    check(WD_FAULT_OUT_N === 1'b1, "disabled watchdog");
    @(posedge CLOCK);
    WD_ENABLE <= 1'b1;
    repeat (4) @(posedge CLOCK);
    bus_read(supervisor_pkg::REG_STATUS);
    check(rd[supervisor_pkg::ST_SETUP] === 1'b1, "set-up interval");
    @(posedge CLOCK);
    VMIN_OK <= 1'b0;
    wait_for(0, 1'b0, 4, 1);
    @(negedge CLOCK);
    check(WD_FAULT_OUT_N === 1'b1, "fault off below minimum supply");
    bus_read(8'h40);
    check(resp === supervisor_pkg::RESP_DECERR && rd === 32'h0000_0000, "unmapped read");
    bus_write(8'h40, 32'h0000_FFFF);
    check(resp === supervisor_pkg::RESP_DECERR, "unmapped write");
    bus_read(supervisor_pkg::REG_CAP_TIMEOUT);
    check(rd === 32'h0000_0028, "cap timeout kept");
    // only byte 0 enabled: the upper bytes of the word must be left alone
    WSTRB <= 4'h1;
    bus_write(supervisor_pkg::REG_CAP_TIMEOUT, 32'hFFFF_FF33);
    bus_read(supervisor_pkg::REG_CAP_TIMEOUT);
    check(rd === 32'h0000_0033, "byte strobe");
    report_and_stop();
  end
endmodule
